// ---- rtl/cise_params.svh ----
`ifndef CISE_PARAMS_SVH
`define CISE_PARAMS_SVH

// Opcode prefixes in the instruction word
`define CISE_OP_DECSKIP   7'h13
`define CISE_OP_SUBW      7'h02
`define CISE_OP_SUBWB     7'h01
`define CISE_OP_JUMP      3'h6
// Field positions and constant values
`define CISE_OP7_HI       15
`define CISE_OP7_LO       9
`define CISE_OP3_HI       15
`define CISE_OP3_LO       13
`define CISE_DEST_BIT     8
`define CISE_JLIT_HI      12
`define CISE_JLIT_MSB     12
`define CISE_JLIT_HLO     8
`define CISE_NOP_WORD     16'h0000
`define CISE_ZERO8        8'h00
`define CISE_ONE8         8'h01
`define CISE_ZERO16       16'h0000
`define CISE_QUARTERS     2'h3

`endif

// ---- rtl/cise_pkg.sv ----
package cise_pkg;
    typedef enum logic [1:0] {
        CISE_Q1 = 2'b00,
        CISE_Q2 = 2'b01,
        CISE_Q3 = 2'b11,
        CISE_Q4 = 2'b10
    } cise_phase_e;

    typedef enum logic [2:0] {
        CISE_OTHER   = 3'h0,
        CISE_DECSKIP = 3'h1,
        CISE_JUMP    = 3'h2,
        CISE_SUBW    = 3'h3,
        CISE_SUBWB   = 3'h4
    } cise_kind_e;
endpackage : cise_pkg

// ---- rtl/cise_core.sv ----
`timescale 1ns/1ps
`include "cise_params.svh"

// Overview of operation
// - Decrement-skip: decode, write f minus one, flags kept
// - Nonzero result discards prefetch, forced no-op cycle
// - Jump loads PC low bits and high latch
// - Jump takes two cycles, flags unchanged
// - Subtract W from f, destination selected
// - Subtracts update overflow, carry, digit carry, zero
// - Borrow subtract uses inverted carry as borrow
// - Borrow subtract decode, one word, one cycle
module cise_core
    import cise_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        instr_valid,
    input  wire logic [15:0] instr_word,
    input  wire logic [7:0]  file_rdata,
    output logic [7:0]       file_addr,
    output logic [7:0]       file_wdata,
    output logic             file_we,
    output logic [7:0]       working_register,
    output logic [15:0]      pc,
    output logic [7:0]       pc_high_latch,
    output logic             overflow_flag,
    output logic             carry_flag,
    output logic             digit_carry_flag,
    output logic             zero_flag,
    output logic             flush,
    output logic             cycle_end
);

    cise_phase_e phase;
    cise_kind_e  kind;
    logic [15:0] ir;
    logic        in_flush;
    logic [8:0]  diff;
    logic [4:0]  nib;
    logic [7:0]  dec_val;
    logic        bin;

    function automatic cise_kind_e decode(input logic [15:0] w);
        cise_kind_e k;
        k = CISE_OTHER;
        if (w[`CISE_OP7_HI:`CISE_OP7_LO] == `CISE_OP_DECSKIP)
            k = CISE_DECSKIP;
        else if (w[`CISE_OP7_HI:`CISE_OP7_LO] == `CISE_OP_SUBW)
            k = CISE_SUBW;
        else if (w[`CISE_OP7_HI:`CISE_OP7_LO] == `CISE_OP_SUBWB)
            k = CISE_SUBWB;
        else if (w[`CISE_OP3_HI:`CISE_OP3_LO] == `CISE_OP_JUMP)
            k = CISE_JUMP;
        return k;
    endfunction : decode

    // f + ~W + carry_in: two's complement subtract
    always_comb begin
        bin  = (kind == CISE_SUBWB) ? carry_flag : 1'b1;
        diff = {1'b0, file_rdata} + {1'b0, ~working_register} + {8'h00, bin};
        nib  = {1'b0, file_rdata[3:0]} + {1'b0, ~working_register[3:0]} + {4'h0, bin};
        dec_val = file_rdata - `CISE_ONE8;
    end

    // Quarter-cycle sequencer
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            phase <= CISE_Q1;
        end else begin
            unique case (phase)
                CISE_Q1: phase <= CISE_Q2;
                CISE_Q2: phase <= CISE_Q3;
                CISE_Q3: phase <= CISE_Q4;
                CISE_Q4: phase <= CISE_Q1;
            endcase
        end
    end

    // Q1 latch; a flushed slot runs as forced no-op
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            ir   <= `CISE_NOP_WORD;
            kind <= CISE_OTHER;
            file_addr <= `CISE_ZERO8;
        end else if (phase == CISE_Q1) begin
            if (in_flush || !instr_valid) begin
                ir   <= `CISE_NOP_WORD;
                kind <= CISE_OTHER;
            end else begin
                ir   <= instr_word;
                kind <= decode(instr_word);
                file_addr <= instr_word[7:0];
            end
        end
    end

    // Flush marks the next slot; held one instruction cycle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            in_flush <= 1'b0;
            flush    <= 1'b0;
        end else if (phase == CISE_Q4) begin
            in_flush <= (kind == CISE_JUMP) ||
                        (kind == CISE_DECSKIP && dec_val != `CISE_ZERO8);
            flush    <= (kind == CISE_JUMP) ||
                        (kind == CISE_DECSKIP && dec_val != `CISE_ZERO8);
        end
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n)
            cycle_end <= 1'b0;
        else
            cycle_end <= (phase == CISE_Q4);
    end

    // Destination write at Q4
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            file_we          <= 1'b0;
            file_wdata       <= `CISE_ZERO8;
            working_register <= `CISE_ZERO8;
        end else begin
            file_we <= 1'b0;
            if (phase == CISE_Q4) begin
                if (kind == CISE_DECSKIP) begin
                    if (ir[`CISE_DEST_BIT]) begin
                        file_we    <= 1'b1;
                        file_wdata <= dec_val;
                    end else begin
                        working_register <= dec_val;
                    end
                end else if (kind == CISE_SUBW || kind == CISE_SUBWB) begin
                    if (ir[`CISE_DEST_BIT]) begin
                        file_we    <= 1'b1;
                        file_wdata <= diff[7:0];
                    end else begin
                        working_register <= diff[7:0];
                    end
                end
            end
        end
    end

    // Status flags; only the subtracts touch them
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            overflow_flag    <= 1'b0;
            carry_flag       <= 1'b0;
            digit_carry_flag <= 1'b0;
            zero_flag        <= 1'b0;
        end else if (phase == CISE_Q4 && (kind == CISE_SUBW || kind == CISE_SUBWB)) begin
            carry_flag       <= diff[8];
            digit_carry_flag <= nib[4];
            zero_flag        <= (diff[7:0] == `CISE_ZERO8);
            overflow_flag    <= (file_rdata[7] != working_register[7]) &&
                                (diff[7] != file_rdata[7]);
        end
    end

    // Program counter and high latch
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pc            <= `CISE_ZERO16;
            pc_high_latch <= `CISE_ZERO8;
        end else if (phase == CISE_Q4) begin
            if (kind == CISE_JUMP) begin
                pc[`CISE_JLIT_HI:0] <= ir[`CISE_JLIT_HI:0];
                pc_high_latch <= {pc[15:13], ir[`CISE_JLIT_MSB:`CISE_JLIT_HLO]};
            end else begin
                pc <= pc + 16'h0001;
            end
        end
    end

    a_jump_flush: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_JUMP) |=> in_flush)
        else $error("jump did not flush prefetch");
    // File data may move right after Q4, so judge the value used at Q4
    a_dec_skip: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_DECSKIP)
        |=> (in_flush == ($past(dec_val) != `CISE_ZERO8)))
        else $error("skip decision wrong");
    a_dec_flags: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_DECSKIP)
        |=> $stable(carry_flag) && $stable(zero_flag) && $stable(overflow_flag)
            && $stable(digit_carry_flag))
        else $error("decrement changed flags");
    a_jump_pc: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_JUMP) |=> pc[12:0] == $past(ir[12:0]))
        else $error("jump target wrong");
    a_jump_latch: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_JUMP)
        |=> pc_high_latch == {$past(pc[15:13]), $past(ir[12:8])})
        else $error("high latch wrong");
    a_sub_zero: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_SUBW && file_rdata == working_register)
        |=> zero_flag && carry_flag)
        else $error("zero result flags wrong");
    a_sub_dest: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q4 && kind == CISE_SUBW && ir[8]) |=> file_we ##1 !file_we)
        else $error("file write missing");
    a_flush_slot: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q1 && in_flush) |=> kind == CISE_OTHER ##3 !in_flush)
        else $error("flushed slot executed");
    a_borrow_one: assert property (@(posedge clock) disable iff (!rst_n)
        (phase == CISE_Q1 && !in_flush && instr_valid && decode(instr_word) == CISE_SUBWB)
        |=> ##3 !in_flush)
        else $error("borrow subtract took two cycles");

endmodule : cise_core

// ---- tb/cise_core_tb_top.sv ----
`timescale 1ns/1ps
`include "cise_params.svh"
module cise_core_tb_top;
    import cise_pkg::*;
    logic        clock;
    logic        rst_n;
    logic        instr_valid;
    logic [15:0] instr_word;
    logic [7:0]  file_rdata, file_addr, file_wdata, working_register, pc_high_latch;
    logic [15:0] pc;
    logic        overflow_flag, carry_flag, digit_carry_flag, zero_flag, flush, cycle_end;
    logic        file_we;
    logic [7:0]  w_m, res, lat_m;
    logic [3:0]  flg_m;
    logic        fl_pend, chk_fw, chk_pc, warm;
    logic [12:0] jk;
    logic [15:0] pc_m;
    logic [31:0] r;
    integer      seed, n_fail, tests_run;

    cise_core i_dut (.clock(clock), .rst_n(rst_n), .instr_valid(instr_valid),
        .instr_word(instr_word), .file_rdata(file_rdata), .file_addr(file_addr),
        .file_wdata(file_wdata), .file_we(file_we), .working_register(working_register),
        .pc(pc),
        .pc_high_latch(pc_high_latch), .overflow_flag(overflow_flag),
        .carry_flag(carry_flag), .digit_carry_flag(digit_carry_flag),
        .zero_flag(zero_flag), .flush(flush), .cycle_end(cycle_end));

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // Expected {overflow, carry, digit carry, zero, result} of f - w - borrow
    function automatic logic [11:0] sub_exp(input logic [7:0] f, input logic [7:0] w,
                                            input logic bw);
        logic [8:0] full;
        logic [4:0] low;
        full = {1'b0, f} - {1'b0, w} - {8'h00, bw};
        low  = {1'b0, f[3:0]} - {1'b0, w[3:0]} - {4'h0, bw};
        return {(f[7] != w[7]) && (full[7] != f[7]), !full[8], !low[4], full[7:0] == 8'h00,
                full[7:0]};
    endfunction : sub_exp

    // Driven on the Q4 edge so the next Q1 edge takes it; results checked mid-cycle
    task automatic exec(input logic [15:0] word, input logic [7:0] f);
        logic       wr;
        logic       bw;
        instr_word <= word;
        file_rdata <= f;
        instr_valid <= 1'b1;
        // cycle_end and file_we of the previous slot stand only one clock after its Q4 edge; flush holds the whole cycle
        #1;
        chk("cycle_end", {15'h0, cycle_end}, {15'h0, warm});
        chk("file_we", {15'h0, file_we}, {15'h0, chk_fw});
        chk("flush", {15'h0, flush}, {15'h0, fl_pend});
        warm = 1'b1;
        repeat (2) @(posedge clock);
        #1;
        chk("cycle_end_low", {15'h0, cycle_end}, 16'h0000);
        chk("file_we_low", {15'h0, file_we}, 16'h0000);
        chk("pc", pc, pc_m);
        chk("working_register", {8'h00, working_register}, {8'h00, w_m});
        chk("flags", {12'h000, overflow_flag, carry_flag, digit_carry_flag, zero_flag},
            {12'h000, flg_m});
        if (chk_fw) chk("file_wdata", {8'h00, file_wdata}, {8'h00, res});
        if (chk_pc) chk("pc_low", {3'h0, pc[12:0]}, {3'h0, jk});
        if (chk_pc) chk("pc_high_latch", {8'h00, pc_high_latch}, {8'h00, lat_m});
        wr = fl_pend;
        fl_pend = 1'b0;
        chk_fw = 1'b0;
        chk_pc = 1'b0;
        if (!wr) begin
            chk("file_addr", {8'h00, file_addr}, {8'h00, word[7:0]});
            if (word[15:9] == `CISE_OP_DECSKIP) begin
                res = f - 8'h01;
                fl_pend = (res != 8'h00);
                wr = 1'b1;
            end else if (word[15:9] == `CISE_OP_SUBW || word[15:9] == `CISE_OP_SUBWB) begin
                bw = (word[15:9] == `CISE_OP_SUBWB) && !flg_m[2];
                {flg_m, res} = sub_exp(f, w_m, bw);
                wr = 1'b1;
            end else if (word[15:13] == `CISE_OP_JUMP) begin
                jk = word[12:0];
                lat_m = {pc_m[15:13], word[12:8]};
                fl_pend = 1'b1;
                chk_pc = 1'b1;
            end
            chk_fw = wr && word[8];
            if (wr && !word[8]) w_m = res;
        end
        if (chk_pc) pc_m[12:0] = jk;
        else pc_m = pc_m + 16'h0001;
        repeat (2) @(posedge clock);
    endtask : exec

    task automatic summarize();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : summarize

    initial begin
        rst_n = 1'b0;
        instr_valid = 1'b0;
        instr_word = 16'h0000;
        file_rdata = 8'h00;
        {w_m, res, flg_m, fl_pend, chk_fw, chk_pc, jk} = '0;
        {lat_m, pc_m, warm} = '0;
        seed = 53327;
        n_fail = 0;
        tests_run = 0;
        repeat (16) @(posedge clock);
        rst_n <= 1'b1;
        // Zero result takes one cycle, nonzero skips the SUBW behind it
        exec({`CISE_OP_SUBW, 1'b0, 8'h21}, 8'h05);
        exec({`CISE_OP_DECSKIP, 1'b0, 8'h22}, 8'h01);
        exec({`CISE_OP_DECSKIP, 1'b1, 8'h23}, 8'h00);
        exec({`CISE_OP_SUBW, 1'b0, 8'h24}, 8'h77);
        exec({`CISE_OP_SUBW, 1'b0, 8'h25}, 8'h80);
        exec({`CISE_OP_SUBWB, 1'b1, 8'h26}, 8'h80);
        exec({`CISE_OP_SUBWB, 1'b0, 8'h27}, 8'h10);
        repeat (300) begin
            r = $random(seed);
            case (r[1:0])
                2'd0: exec({`CISE_OP_DECSKIP, r[2], r[15:8]}, r[23:16]);
                2'd1: exec({`CISE_OP_SUBW, r[2], r[15:8]}, r[23:16]);
                2'd2: exec({`CISE_OP_SUBWB, r[2], r[15:8]}, r[23:16]);
                default: exec({`CISE_OP_JUMP, 1'b0, r[27:16]}, r[31:24]);
            endcase
        end
        // Top of the jump range, then a slot that must be discarded
        exec({`CISE_OP_JUMP, 13'h1FFF}, 8'h00);
        exec({`CISE_OP_SUBW, 1'b0, 8'h30}, 8'h55);
        exec(`CISE_NOP_WORD, 8'h00);
        exec(`CISE_NOP_WORD, 8'h00);
        summarize();
    end
endmodule : cise_core_tb_top
